// ===== src/fot_top.v
// Purpose: output-enable control for standard and parallel-port floppy pins
// Assumes: register port in the system clock domain, auto power-down
//   conditions supplied as one level from the power logic
// Notes: pin data are active-low levels from the controller core
`timescale 1ns/1ps
`default_nettype none
`include "fot_defs.vh"

module fot_top (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [`FOT_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire auto_idle_i,
  input wire write_data_out_i,
  input wire drive_density_out_i,
  input wire head_select_out_i,
  input wire write_gate_out_i,
  input wire step_direction_out_i,
  input wire step_pulse_out_i,
  input wire drive_select_zero_i,
  input wire drive_select_one_i,
  input wire motor_on_zero_i,
  input wire motor_on_one_i,
  input wire [`FOT_OUT_W-1:0] pp_data_i,
  output wire [`FOT_OUT_W-1:0] std_pin_o,
  output wire [`FOT_OUT_W-1:0] std_oe_o,
  output wire [`FOT_OUT_W-1:0] pp_pin_o,
  output wire [`FOT_OUT_W-1:0] pp_oe_o
);

  // ==========================================================
  // register storage
  reg activate;
  reg [7:0] base_hi;
  reg [7:0] base_lo;
  reg [7:0] floppy_mode_config_reg;
  reg [7:0] rate_reg;
  reg [7:0] global_floppy_power_config;
  reg [7:0] global_floppy_auto_power_config;
  reg auto_idle_meta;
  reg auto_idle_sync;
  reg [7:0] next_rdata;

  // level from the power logic runs on another clock, so resync it
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      auto_idle_meta <= 1'b0;
      auto_idle_sync <= 1'b0;
    end
    else
    begin
      auto_idle_meta <= auto_idle_i;
      auto_idle_sync <= auto_idle_meta;
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      activate <= 1'b0;
      base_hi <= `FOT_RST_BASE_HI;
      base_lo <= `FOT_RST_BASE_LO;
      floppy_mode_config_reg <= `FOT_RST_BYTE;
      rate_reg <= `FOT_RST_BYTE;
      global_floppy_power_config <= `FOT_RST_POWER;
      global_floppy_auto_power_config <= `FOT_RST_BYTE;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `FOT_OFS_ACTIVATE:
        begin
          activate <= wdata_i[`FOT_BIT_ACTIVATE];
        end
        `FOT_OFS_BASE_HI:
        begin
          base_hi <= wdata_i;
        end
        `FOT_OFS_BASE_LO:
        begin
          base_lo <= wdata_i;
        end
        `FOT_OFS_MODE:
        begin
          floppy_mode_config_reg <= wdata_i;
        end
        `FOT_OFS_RATE:
        begin
          rate_reg <= wdata_i;
        end
        `FOT_OFS_POWER:
        begin
          global_floppy_power_config <= wdata_i;
        end
        `FOT_OFS_AUTO:
        begin
          global_floppy_auto_power_config <= wdata_i;
        end
        // status and cause are read only; a write there is dropped
        default:
        begin
          activate <= activate;
        end
      endcase
    end
  end

  // ==========================================================
  // float conditions
  function base_ok;
    input [15:0] b;
    begin
      base_ok = (b > `FOT_BASE_MIN) && (b < `FOT_BASE_MAX);
    end
  endfunction

  wire base_valid = base_ok({base_hi, base_lo});
  wire power_on = global_floppy_power_config[`FOT_BIT_POWER];
  wire manual_down = rate_reg[`FOT_BIT_PWR_DOWN];
  wire auto_en = global_floppy_auto_power_config[`FOT_BIT_AUTO];
  // manual power-down wins regardless of the auto state
  wire auto_down = auto_en & auto_idle_sync;
  wire powered_down = manual_down | auto_down;
  wire dev_float = ~activate | ~base_valid | ~power_on | powered_down;
  wire out_ctrl = floppy_mode_config_reg[`FOT_BIT_OUT_CTRL];
  wire std_en = ~(dev_float | out_ctrl);
  wire pp_en = ~dev_float;

  wire [`FOT_OUT_W-1:0] std_data = {motor_on_one_i, motor_on_zero_i,
    drive_select_one_i, drive_select_zero_i, step_pulse_out_i,
    step_direction_out_i, write_gate_out_i, head_select_out_i,
    drive_density_out_i, write_data_out_i};

  // ==========================================================
  // pin-state tracker
  // registered beside the gate flops, so a status read reports
  // the state the cable really sees, not the one about to come
  localparam GS_FLOAT = 2'b00;
  localparam GS_PORT = 2'b01;
  localparam GS_ALL = 2'b10;

  reg [1:0] gate_state;
  reg [1:0] next_gate_state;

  // one decode shared by every state branch
  function [1:0] gate_code;
    input pp_on;
    input std_on;
    begin
      if (pp_on && std_on)
        gate_code = GS_ALL;
      else if (pp_on)
        gate_code = GS_PORT;
      else
        gate_code = GS_FLOAT;
    end
  endfunction

  always @*
  begin
    next_gate_state = GS_FLOAT;
    case (gate_state)
      GS_FLOAT:
      begin
        next_gate_state = gate_code(pp_en, std_en);
      end
      GS_PORT:
      begin
        next_gate_state = gate_code(pp_en, std_en);
      end
      GS_ALL:
      begin
        next_gate_state = gate_code(pp_en, std_en);
      end
      // the spare code cannot be reached; park it floating
      default:
      begin
        next_gate_state = GS_FLOAT;
      end
    endcase
  end

  always @(posedge clk_sys_i)
  begin
    if (reset_i)
      gate_state <= GS_FLOAT;
    else
      gate_state <= next_gate_state;
  end

  // ==========================================================
  // float cause snapshot
  // one bit per float condition other than output control, so software can tell which
  // mechanism holds the pins off; a plain level, not sticky
  reg [`FOT_CAUSE_W-1:0] float_cause;

  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      float_cause <= {`FOT_CAUSE_W{1'b0}};
    end
    else
    begin
      float_cause <= {auto_down, manual_down, ~power_on, ~base_valid,
        ~activate};
    end
  end

  // ==========================================================
  // pin gating
  fot_gate #(.WIDTH(`FOT_OUT_W)) u_std (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .enable_i(std_en),
    .data_i(std_data),
    .data_o(std_pin_o),
    .oe_o(std_oe_o)
  );

  fot_gate #(.WIDTH(`FOT_OUT_W)) u_pp (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .enable_i(pp_en),
    .data_i(pp_data_i),
    .data_o(pp_pin_o),
    .oe_o(pp_oe_o)
  );

  // ==========================================================
  // read port; unmapped offsets read zero
  always @*
  begin
    next_rdata = `FOT_RST_BYTE;
    case (addr_i)
      `FOT_OFS_ACTIVATE:
      begin
        next_rdata = {7'b0, activate};
      end
      `FOT_OFS_BASE_HI:
      begin
        next_rdata = base_hi;
      end
      `FOT_OFS_BASE_LO:
      begin
        next_rdata = base_lo;
      end
      `FOT_OFS_MODE:
      begin
        next_rdata = floppy_mode_config_reg;
      end
      `FOT_OFS_RATE:
      begin
        next_rdata = rate_reg;
      end
      `FOT_OFS_POWER:
      begin
        next_rdata = global_floppy_power_config;
      end
      `FOT_OFS_AUTO:
      begin
        next_rdata = global_floppy_auto_power_config;
      end
      `FOT_OFS_STATUS:
      begin
        next_rdata = {1'b0, gate_state, auto_down, base_valid,
          powered_down, pp_en, std_en};
      end
      `FOT_OFS_CAUSE:
      begin
        next_rdata = {3'b0, float_cause};
      end
      default:
      begin
        next_rdata = `FOT_RST_BYTE;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      rdata_o <= `FOT_RST_BYTE;
    end
    else if (rd_i)
    begin
      rdata_o <= next_rdata;
    end
    else
    begin
      rdata_o <= `FOT_RST_BYTE;
    end
  end

endmodule
`default_nettype wire

// ===== include/fot_defs.vh
// Purpose: constants for the floppy output tri-state control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: offsets below 0x20 are local registers of this block
//
// What this block does
// - float drive outputs when deactivated or powered down
// - output-control bit floats standard floppy outputs
// - output-control bit leaves parallel-port outputs alone
// - both sets drive only when fully enabled
// - invalid base address floats the outputs
// - global power bit clear floats the outputs
// - manual power-down bit floats the outputs
// - manual power-down overrides automatic power management
// - global auto-power bit enables automatic management
// - auto mode floats only when all conditions hold
// - gating covers all ten drive outputs
`ifndef FOT_DEFS_VH
`define FOT_DEFS_VH

// ==========================================================
// register offsets
`define FOT_ADDR_W 8
`define FOT_OFS_ACTIVATE 8'h_0030
`define FOT_OFS_BASE_HI 8'h_0060
`define FOT_OFS_BASE_LO 8'h_0061
`define FOT_OFS_MODE 8'h_00F0
`define FOT_OFS_RATE 8'h_0004
`define FOT_OFS_POWER 8'h_0022
`define FOT_OFS_AUTO 8'h_0023
`define FOT_OFS_STATUS 8'h_0010
`define FOT_OFS_CAUSE 8'h_0011
`define FOT_CAUSE_W 5

// ==========================================================
// field positions
`define FOT_BIT_ACTIVATE 0
`define FOT_BIT_OUT_CTRL 7
`define FOT_BIT_PWR_DOWN 6
`define FOT_BIT_POWER 0
`define FOT_BIT_AUTO 0

// ==========================================================
// base address window and reset values
`define FOT_BASE_MIN 16'h_0100
`define FOT_BASE_MAX 16'h_0FF8
`define FOT_RST_BYTE 8'h_00
`define FOT_RST_POWER 8'h_01
`define FOT_RST_BASE_HI 8'h_03
`define FOT_RST_BASE_LO 8'h_F0
`define FOT_OUT_W 10

`endif

// ===== src/fot_gate.v
// Purpose: registered enable and pin gating for floppy drive outputs
// Assumes: the enable terms arrive on the same clock
// Notes: outputs are flops, enables and data move together
`timescale 1ns/1ps
`default_nettype none
`include "fot_defs.vh"

module fot_gate #(
  parameter WIDTH = `FOT_OUT_W
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire enable_i,
  input wire [WIDTH-1:0] data_i,
  output reg [WIDTH-1:0] data_o,
  output reg [WIDTH-1:0] oe_o
);

  // ==========================================================
  // per-pin flops
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : pin
      always @(posedge clk_sys_i)
      begin
        if (reset_i)
        begin
          data_o[g] <= 1'b1;
          oe_o[g] <= 1'b0;
        end
        else
        begin
          data_o[g] <= data_i[g];
          oe_o[g] <= enable_i;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== verification/fot_drive_model.sv
// Purpose: drive-side view of the floppy cable lines
// Assumes: drive terminators pull every line up
// Notes: a floated line reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module fot_drive_model (
  input wire logic [9:0] pin_i,
  input wire logic [9:0] oe_i,
  output logic [9:0] line_o
);
  // ==========
  // cable resolution
  assign line_o = pin_i | ~oe_i;
endmodule
`default_nettype wire

// ===== verification/fot_top_monitor.sv
// Purpose: port checker for fot_top
// Assumes: enables settle by the second edge after the write edge
// Notes: register state is not mirrored, only write causes
`timescale 1ns/1ps
`default_nettype none
`include "fot_defs.vh"
module fot_top_monitor (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic [9:0] pp_data_i,
  input wire logic [9:0] std_oe_o,
  input wire logic [9:0] pp_oe_o,
  input wire logic [9:0] pp_pin_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // ==========
  // write decode
  wire off = ~|std_oe_o && ~|pp_oe_o;
  wire [7:0] a = wr_i ? addr_i : 8'h_00;
  wire [7:0] d = wdata_i;
  act_off_a: assert property (a == `FOT_OFS_ACTIVATE && !d[0] |-> ##2 off)
    else $error("pins driven after deactivate");
  mode_off_a: assert property (a == `FOT_OFS_MODE && d[7] |-> ##2 ~|std_oe_o)
    else $error("standard pins driven with output control set");
  std_pp_a: assert property (|std_oe_o |-> &pp_oe_o)
    else $error("standard pins on without port pins");
  base_off_a: assert property (a == `FOT_OFS_BASE_HI && d == 8'h_00 |-> ##2 off)
    else $error("pins driven with low base");
  pwr_off_a: assert property (a == `FOT_OFS_POWER && !d[0] |-> ##2 off)
    else $error("pins driven with power off");
  pd_off_a: assert property (a == `FOT_OFS_RATE && d[6] |-> ##2 off)
    else $error("pins driven in manual power-down");
  std_same_a: assert property (std_oe_o == 10'h_0000 || &std_oe_o)
    else $error("standard enables differ");
  pp_same_a: assert property (pp_oe_o == 10'h_0000 || &pp_oe_o)
    else $error("port enables differ");
  pp_copy_a: assert property (!$past(reset_i) |-> pp_pin_o == $past(pp_data_i))
    else $error("port pin data lost");
  cover property (|std_oe_o);
  cover property (&pp_oe_o && ~|std_oe_o);
  cover property (a == `FOT_OFS_AUTO && d[0]);
endmodule
bind fot_top fot_top_monitor mon (.*);
`default_nettype wire

// ===== verification/test_fot_top.sv
// Purpose: register-driven test of floppy output gating
// Assumes: enables settle within five edges of a write
// Notes: floated cable lines read high through the drive model
`timescale 1ns/1ps
`default_nettype none
`include "fot_defs.vh"
module test_fot_top;
  logic clk_sys_i = 0, reset_i = 1, wr = 0, rd = 0, idle = 0;
  logic [7:0] addr = 0, wdata = 0;
  logic [9:0] sd = 10'h_0155, pd = 10'h_02A5;
  wire [7:0] rdata;
  wire [9:0] sp, so, pp, po, line;
  int fail_count = 0, compares = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  fot_top dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .auto_idle_i(idle), .write_data_out_i(sd[0]),
    .drive_density_out_i(sd[1]), .head_select_out_i(sd[2]),
    .write_gate_out_i(sd[3]), .step_direction_out_i(sd[4]),
    .step_pulse_out_i(sd[5]), .drive_select_zero_i(sd[6]),
    .drive_select_one_i(sd[7]), .motor_on_zero_i(sd[8]),
    .motor_on_one_i(sd[9]), .pp_data_i(pd), .std_pin_o(sp),
    .std_oe_o(so), .pp_pin_o(pp), .pp_oe_o(po));
  fot_drive_model drv (.pin_i(sp), .oe_i(so), .line_o(line));
  // ==========
  // tasks
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [9:0] e, g);
    compares++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask
  task wrr(input logic [7:0] a, v);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clk_sys_i);
    wr <= 0;
  endtask
  task rdc(input logic [7:0] a, e);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1;
    @(posedge clk_sys_i);
    rd <= 0;
    #1 chk("rdata", {2'b00, e}, {2'b00, rdata});
  endtask
  // both enables and the cable as the drive sees it
  task st(input logic s, p);
    repeat (5) @(posedge clk_sys_i);
    #1 chk("std_oe", {10{s}}, so);
    chk("pp_oe", {10{p}}, po);
    chk("line", s ? sd : 10'h_03FF, line);
  endtask
  // ==========
  // tests
  initial
  begin
    repeat (2000) @(posedge clk_sys_i);
    fail_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 0;
    rdc(`FOT_OFS_POWER, 8'h_01);
    rdc(`FOT_OFS_AUTO, 8'h_00);
    rdc(8'h_55, 8'h_00);
    st(0, 0);
    wrr(`FOT_OFS_ACTIVATE, 8'h_01);
    st(1, 1);
    wrr(`FOT_OFS_MODE, 8'h_80);
    st(0, 1);
    rdc(`FOT_OFS_STATUS, 8'h_2A);
    wrr(`FOT_OFS_MODE, 8'h_00);
    wrr(`FOT_OFS_POWER, 8'h_00);
    st(0, 0);
    rdc(`FOT_OFS_CAUSE, 8'h_04);
    wrr(`FOT_OFS_POWER, 8'h_01);
    wrr(`FOT_OFS_RATE, 8'h_40);
    st(0, 0);
    wrr(`FOT_OFS_RATE, 8'h_00);
    wrr(`FOT_OFS_BASE_HI, 8'h_00);
    st(0, 0);
    wrr(`FOT_OFS_BASE_HI, 8'h_01);
    wrr(`FOT_OFS_BASE_LO, 8'h_00);
    st(0, 0);
    wrr(`FOT_OFS_BASE_HI, 8'h_0F);
    wrr(`FOT_OFS_BASE_LO, 8'h_F8);
    st(0, 0);
    wrr(`FOT_OFS_BASE_LO, 8'h_F7);
    idle <= 1;
    st(1, 1);
    wrr(`FOT_OFS_AUTO, 8'h_01);
    st(0, 0);
    idle <= 0;
    st(1, 1);
    wrr(`FOT_OFS_RATE, 8'h_40);
    st(0, 0);
    wrr(`FOT_OFS_RATE, 8'h_00);
    sd <= 10'h_02AA;
    pd <= 10'h_0155;
    st(1, 1);
    chk("std_pin", sd, sp);
    chk("pp_pin", pd, pp);
    rdc(`FOT_OFS_STATUS, 8'h_4B);
    wrr(`FOT_OFS_ACTIVATE, 8'h_00);
    st(0, 0);
    rdc(`FOT_OFS_CAUSE, 8'h_01);
    rdc(`FOT_OFS_STATUS, 8'h_08);
    report_and_stop;
  end
endmodule
`default_nettype wire
